// file: rtl/device_address_decoder.sv
// Address decoder with register-space steering, part identifier and local-to-global mapping
`default_nettype none
module device_address_decoder
  import addr_decode_pkg::*;
#(
  parameter logic [3:0] MAJOR_FAMILY = 4'h1,    // Arbitrary value
  parameter logic [5:0] MINOR_FAMILY = 6'h01,   // Arbitrary value
  parameter logic [1:0] MAJOR_REV    = 2'h0,    // Arbitrary value
  parameter logic [3:0] MINOR_REV    = 4'h0,    // Arbitrary value
  parameter logic       RAM_4K       = 1'b0,
  parameter logic [15:0] NVM_VERSION = 16'h0000 // Arbitrary value
) (
  input  wire logic                 sys_clk,
  input  wire logic                 reset_n,
  input  wire logic                 clk_en,
  input  wire logic                 acc_valid,
  input  wire logic                 acc_write,
  input  wire logic [15:0]          acc_addr,
  input  wire logic [7:0]           acc_wdata,
  input  wire logic [PAGE_W-1:0]    flash_page_select,
  output var  logic                 tgt_valid_reg,
  output var  logic                 tgt_write_reg,
  output var  addr_decode_pkg::target_t tgt_sel_reg,
  output var  logic [17:0]          tgt_gaddr_reg,
  output var  logic [7:0]           tgt_wdata_reg,
  output var  logic                 local_rvalid_reg,
  output var  logic [7:0]           local_rdata_reg,
  output var  logic [15:0]          nvm_version_word_reg
);

  // Window hits
  wire logic in_reg   = acc_addr <= REG_SPACE_END;
  wire logic h_port   = (acc_addr <= PIM_A_HI)
                     || (acc_addr >= PIM_B_LO && acc_addr <= PIM_B_HI)
                     || (acc_addr >= PIM_C_LO && acc_addr <= PIM_C_HI)
                     || (acc_addr >= PIM_D_LO && acc_addr <= PIM_D_HI);
  wire logic h_mmc    = (acc_addr >= MMC_A_LO && acc_addr <= MMC_A_HI)
                     || (acc_addr >= MMC_B_LO && acc_addr <= MMC_B_HI);
  wire logic h_ident  = acc_addr == PART_IDENT_HIGH_OFS || acc_addr == PART_IDENT_LOW_OFS;
  wire logic h_clock  = (acc_addr >= CLK_A_LO && acc_addr <= CLK_A_HI)
                     || (acc_addr >= CLK_B_LO && acc_addr <= CLK_B_HI);
  wire logic h_adc    = acc_addr >= ADC_LO && acc_addr <= ADC_HI;
  wire logic h_pwm    = acc_addr >= PWM_LO && acc_addr <= PWM_HI;
  wire logic h_spi    = acc_addr >= SPI_LO && acc_addr <= SPI_HI;
  wire logic h_timer  = acc_addr >= TMR_LO && acc_addr <= TMR_HI;
  wire logic h_debug  = acc_addr >= DBG_LO && acc_addr <= DBG_HI;
  wire logic h_async  = acc_addr >= ASY_LO && acc_addr <= ASY_HI;
  wire logic h_nvm    = acc_addr >= NVM_LO && acc_addr <= NVM_HI;
  wire logic h_intc   = acc_addr == INT_ADDR;
  wire logic h_can    = acc_addr >= CAN_LO && acc_addr <= CAN_HI;
  wire logic [15:0] ram_hi = RAM_4K ? RAM_HI_4K : RAM_HI_STD;
  wire logic h_dflash = acc_addr >= DFL_LO && acc_addr <= DFL_HI;
  wire logic h_ram    = acc_addr >= RAM_LO && acc_addr <= ram_hi;
  wire logic h_pfl_lo = acc_addr >= PFL_LOW_LO && acc_addr <= PFL_LOW_HI;
  wire logic h_paged  = acc_addr >= PFL_PAGED_LO && acc_addr <= PFL_PAGED_HI;
  wire logic h_pfl_hi = acc_addr >= PFL_HIGH_LO;

  // Register space checked first so memory windows never shadow registers
  target_t sel;
  always_comb begin
    if (in_reg) begin
      if (h_port)       sel = TGT_PORT;
      else if (h_mmc)   sel = TGT_MMC;
      else if (h_ident) sel = TGT_IDENT;
      else if (h_clock) sel = TGT_CLOCK;
      else if (h_adc)   sel = TGT_ADC;
      else if (h_pwm)   sel = TGT_PWM;
      else if (h_spi)   sel = TGT_SPI;
      else if (h_timer) sel = TGT_TIMER;
      else if (h_debug) sel = TGT_DEBUG;
      else if (h_async) sel = TGT_ASYNC;
      else if (h_nvm)   sel = TGT_NVM_REGS;
      else if (h_intc)  sel = TGT_INTC;
      else if (h_can)   sel = TGT_CAN;
      else              sel = TGT_RESERVED;
    end else if (h_dflash) sel = TGT_DFLASH;
    else if (h_ram)     sel = TGT_RAM;
    else if (h_pfl_lo || h_paged || h_pfl_hi) sel = TGT_PFLASH;
    else                sel = TGT_UNMAPPED;
  end

  // Local to global translation
  wire logic [17:0] a18       = {2'b00, acc_addr};
  wire logic [17:0] g_dflash  = a18 + DFL_GLOBAL_OFS;
  wire logic [17:0] g_ram     = a18 + RAM_GLOBAL_OFS;
  wire logic [17:0] g_unpaged = a18 + PFL_GLOBAL_OFS;
  wire logic [17:0] g_paged   = {flash_page_select, acc_addr[PAGE_SHIFT-1:0]};
  wire logic [17:0] gaddr     = (sel == TGT_DFLASH) ? g_dflash
                              : (sel == TGT_RAM)    ? g_ram
                              : (sel == TGT_PFLASH) ? (h_paged ? g_paged : g_unpaged)
                              : a18;

  // Identifier word and local read data
  wire logic [15:0] part_ident = (16'(MAJOR_FAMILY) << ID_MAJFAM_LSB)
                               | (16'(MINOR_FAMILY) << ID_MINFAM_LSB)
                               | (16'(MAJOR_REV) << ID_MAJREV_LSB)
                               | (16'(MINOR_REV) << ID_MINREV_LSB);
  wire logic [7:0] ident_byte = (acc_addr == PART_IDENT_HIGH_OFS) ? part_ident[15:8]
                                                                  : part_ident[7:0];
  wire logic local_hit  = sel == TGT_IDENT || sel == TGT_RESERVED;
  wire logic [7:0] lrd  = (sel == TGT_IDENT) ? ident_byte : READ_ZERO;
  // Writes to reserved or read-only identifier go nowhere
  wire logic fwd = acc_valid && !local_hit;

  // Registered outputs, one cycle behind the request
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tgt_valid_reg    <= 1'b0;
      tgt_write_reg    <= 1'b0;
      tgt_sel_reg      <= TGT_NONE;
      tgt_gaddr_reg    <= '0;
      tgt_wdata_reg    <= '0;
      local_rvalid_reg <= 1'b0;
      local_rdata_reg  <= READ_ZERO;
    end else if (clk_en) begin
      tgt_valid_reg    <= fwd;
      tgt_write_reg    <= fwd && acc_write;
      tgt_sel_reg      <= acc_valid ? sel : TGT_NONE;
      tgt_gaddr_reg    <= gaddr;
      tgt_wdata_reg    <= acc_wdata;
      local_rvalid_reg <= acc_valid && local_hit && !acc_write;
      local_rdata_reg  <= lrd;
    end
  end

  // Controller version word as it would sit in the flash information row
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) nvm_version_word_reg <= '0;
    else if (clk_en) nvm_version_word_reg <= NVM_VERSION;
  end

  // Checks
  sequence s_acc_reserved;
    acc_valid && clk_en && sel == TGT_RESERVED;
  endsequence

  AST_RSV_WRITE_DROPPED: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_acc_reserved |=> !tgt_valid_reg && !tgt_write_reg)
    else $error("reserved write forwarded");
  AST_RSV_READ_ZERO: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_acc_reserved ##0 !acc_write |=> local_rvalid_reg && local_rdata_reg == 8'h00)
    else $error("reserved read not zero");
  AST_PORT_SEL: assert property (@(posedge sys_clk) disable iff (!reset_n)
    acc_valid && clk_en && acc_addr >= 16'h0240 && acc_addr <= 16'h027f
    |=> tgt_sel_reg == TGT_PORT && tgt_valid_reg)
    else $error("port window misrouted");
  AST_MMC_SEL: assert property (@(posedge sys_clk) disable iff (!reset_n)
    acc_valid && clk_en && acc_addr >= 16'h0010 && acc_addr <= 16'h0017 |=> tgt_sel_reg == TGT_MMC)
    else $error("mmc window misrouted");
  AST_CLOCK_SEL: assert property (@(posedge sys_clk) disable iff (!reset_n)
    acc_valid && clk_en && acc_addr >= 16'h02f0 && acc_addr <= 16'h02ff
    |=> tgt_sel_reg == TGT_CLOCK)
    else $error("clock window misrouted");
  AST_ADC_SEL: assert property (@(posedge sys_clk) disable iff (!reset_n)
    acc_valid && clk_en && acc_addr >= 16'h0070 && acc_addr <= 16'h009f |=> tgt_sel_reg == TGT_ADC)
    else $error("adc window misrouted");
  AST_PWM_SEL: assert property (@(posedge sys_clk) disable iff (!reset_n)
    acc_valid && clk_en && acc_addr >= 16'h00a0 && acc_addr <= 16'h00c7 |=> tgt_sel_reg == TGT_PWM)
    else $error("pwm window misrouted");
  AST_SPI_SEL: assert property (@(posedge sys_clk) disable iff (!reset_n)
    acc_valid && clk_en && acc_addr >= 16'h00d8 && acc_addr <= 16'h00df |=> tgt_sel_reg == TGT_SPI)
    else $error("spi window misrouted");
  AST_TIMER_SEL: assert property (@(posedge sys_clk) disable iff (!reset_n)
    acc_valid && clk_en && acc_addr >= 16'h0040 && acc_addr <= 16'h006f
    |=> tgt_sel_reg == TGT_TIMER)
    else $error("timer window misrouted");
  AST_IDENT_HIGH: assert property (@(posedge sys_clk) disable iff (!reset_n)
    acc_valid && clk_en && !acc_write && acc_addr == 16'h001a
    |=> local_rvalid_reg && local_rdata_reg == {MAJOR_FAMILY, MINOR_FAMILY[5:2]})
    else $error("ident high byte wrong");
  AST_IDENT_LOW: assert property (@(posedge sys_clk) disable iff (!reset_n)
    acc_valid && clk_en && !acc_write && acc_addr == 16'h001b
    |=> local_rdata_reg == {MINOR_FAMILY[1:0], MAJOR_REV, MINOR_REV})
    else $error("ident low byte wrong");
  AST_PAGED_MAP: assert property (@(posedge sys_clk) disable iff (!reset_n)
    acc_valid && clk_en && acc_addr[15:14] == 2'b10
    |=> tgt_gaddr_reg == {$past(flash_page_select), $past(acc_addr[13:0])})
    else $error("paged window mapped wrong");
  AST_DFLASH_MAP: assert property (@(posedge sys_clk) disable iff (!reset_n)
    acc_valid && clk_en && acc_addr == 16'h0400 |=> tgt_gaddr_reg == 18'h04400)
    else $error("data flash base mapped wrong");
  AST_UNPAGED_MAP: assert property (@(posedge sys_clk) disable iff (!reset_n)
    acc_valid && clk_en && acc_addr == 16'hc000 |=> tgt_gaddr_reg == 18'h3c000)
    else $error("unpaged flash mapped wrong");
  AST_RAM_MAP: assert property (@(posedge sys_clk) disable iff (!reset_n)
    acc_valid && clk_en && acc_addr == 16'h1400 |=> tgt_gaddr_reg == 18'h31400)
    else $error("ram base mapped wrong");
  AST_REG_PRIORITY: assert property (@(posedge sys_clk) disable iff (!reset_n)
    acc_valid && clk_en && acc_addr <= 16'h03ff
    |=> tgt_sel_reg != TGT_DFLASH && tgt_sel_reg != TGT_RAM && tgt_sel_reg != TGT_PFLASH)
    else $error("memory selected in register space");

  // Further window checks on the low register windows
  AST_PORT_LOW_SEL: assert property (@(posedge sys_clk) disable iff (!reset_n)
    acc_valid && clk_en && acc_addr <= PIM_A_HI
    |=> tgt_sel_reg == TGT_PORT)
    else $error("low port window misrouted");
  AST_PORT_B_SEL: assert property (@(posedge sys_clk) disable iff (!reset_n)
    acc_valid && clk_en && acc_addr >= PIM_B_LO && acc_addr <= PIM_B_HI
    |=> tgt_sel_reg == TGT_PORT)
    else $error("second port window misrouted");
  AST_PORT_C_SEL: assert property (@(posedge sys_clk) disable iff (!reset_n)
    acc_valid && clk_en && acc_addr >= PIM_C_LO && acc_addr <= PIM_C_HI
    |=> tgt_sel_reg == TGT_PORT)
    else $error("third port window misrouted");
  AST_MMC_LOW_SEL: assert property (@(posedge sys_clk) disable iff (!reset_n)
    acc_valid && clk_en && acc_addr >= MMC_A_LO && acc_addr <= MMC_A_HI
    |=> tgt_sel_reg == TGT_MMC)
    else $error("low map control window misrouted");
  AST_CLOCK_LOW_SEL: assert property (@(posedge sys_clk) disable iff (!reset_n)
    acc_valid && clk_en && acc_addr >= CLK_A_LO && acc_addr <= CLK_A_HI
    |=> tgt_sel_reg == TGT_CLOCK)
    else $error("low clock window misrouted");
  AST_DEBUG_SEL: assert property (@(posedge sys_clk) disable iff (!reset_n)
    acc_valid && clk_en && acc_addr >= DBG_LO && acc_addr <= DBG_HI
    |=> tgt_sel_reg == TGT_DEBUG)
    else $error("debug window misrouted");
  AST_ASYNC_SEL: assert property (@(posedge sys_clk) disable iff (!reset_n)
    acc_valid && clk_en && acc_addr >= ASY_LO && acc_addr <= ASY_HI
    |=> tgt_sel_reg == TGT_ASYNC)
    else $error("async serial window misrouted");
  AST_NVM_REGS_SEL: assert property (@(posedge sys_clk) disable iff (!reset_n)
    acc_valid && clk_en && acc_addr >= NVM_LO && acc_addr <= NVM_HI
    |=> tgt_sel_reg == TGT_NVM_REGS)
    else $error("flash control window misrouted");
  AST_INTC_SEL: assert property (@(posedge sys_clk) disable iff (!reset_n)
    acc_valid && clk_en && acc_addr == INT_ADDR
    |=> tgt_sel_reg == TGT_INTC)
    else $error("interrupt location misrouted");
  AST_CAN_SEL: assert property (@(posedge sys_clk) disable iff (!reset_n)
    acc_valid && clk_en && acc_addr >= CAN_LO && acc_addr <= CAN_HI
    |=> tgt_sel_reg == TGT_CAN)
    else $error("network window misrouted");

  // Forwarding steps: a taken access and the answer at the very next clock edge
  sequence s_acc_fwd_write;
    acc_valid && clk_en && acc_write && !local_hit;
  endsequence
  sequence s_acc_fwd_read;
    acc_valid && clk_en && !acc_write && !local_hit;
  endsequence
  sequence s_acc_ident_write;
    acc_valid && clk_en && acc_write && sel == TGT_IDENT;
  endsequence

  AST_FWD_WRITE: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_acc_fwd_write |=> tgt_valid_reg && tgt_write_reg)
    else $error("owned write not forwarded");
  AST_FWD_WDATA: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_acc_fwd_write |=> tgt_wdata_reg == $past(acc_wdata))
    else $error("forwarded write data wrong");
  AST_FWD_READ: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_acc_fwd_read |=> tgt_valid_reg && !tgt_write_reg && !local_rvalid_reg)
    else $error("owned read not forwarded alone");
  AST_IDENT_WRITE_REFUSED: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_acc_ident_write |=> !tgt_valid_reg && !tgt_write_reg && !local_rvalid_reg)
    else $error("identifier write not refused");
  AST_RSV_WRITE_NO_ANSWER: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_acc_reserved ##0 acc_write |=> !local_rvalid_reg && tgt_sel_reg == TGT_RESERVED)
    else $error("reserved write answered");
  AST_IDENT_SEL: assert property (@(posedge sys_clk) disable iff (!reset_n)
    acc_valid && clk_en && (acc_addr == PART_IDENT_HIGH_OFS || acc_addr == PART_IDENT_LOW_OFS)
    |=> tgt_sel_reg == TGT_IDENT)
    else $error("identifier not selected");

  // Idle and frozen behaviour
  AST_IDLE_NONE: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !acc_valid && clk_en
    |=> tgt_sel_reg == TGT_NONE && !tgt_valid_reg && !local_rvalid_reg)
    else $error("target shown without access");
  AST_FREEZE_HOLD: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !clk_en
    |=> $stable(tgt_sel_reg) && $stable(tgt_gaddr_reg) && $stable(tgt_valid_reg))
    else $error("outputs moved while frozen");
  AST_VERSION: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clk_en |=> nvm_version_word_reg == NVM_VERSION)
    else $error("version word wrong");

  // Translation end points
  AST_DFLASH_END: assert property (@(posedge sys_clk) disable iff (!reset_n)
    acc_valid && clk_en && acc_addr == DFL_HI |=> tgt_gaddr_reg == 18'h053ff)
    else $error("data flash end mapped wrong");
  AST_RAM_END: assert property (@(posedge sys_clk) disable iff (!reset_n)
    acc_valid && clk_en && acc_addr == ram_hi
    |=> tgt_gaddr_reg == (RAM_4K ? 18'h32fff : 18'h327ff) && tgt_sel_reg == TGT_RAM)
    else $error("ram end mapped wrong");
  AST_PFL_LOW_MAP: assert property (@(posedge sys_clk) disable iff (!reset_n)
    acc_valid && clk_en && acc_addr == PFL_LOW_LO |=> tgt_gaddr_reg == 18'h34000)
    else $error("low unpaged flash mapped wrong");
  AST_PFL_TOP_MAP: assert property (@(posedge sys_clk) disable iff (!reset_n)
    acc_valid && clk_en && acc_addr == 16'hffff |=> tgt_gaddr_reg == 18'h3ffff)
    else $error("top unpaged flash mapped wrong");
  AST_PAGED_SEL: assert property (@(posedge sys_clk) disable iff (!reset_n)
    acc_valid && clk_en && h_paged |=> tgt_sel_reg == TGT_PFLASH)
    else $error("paged window not flash");
  AST_REG_GADDR: assert property (@(posedge sys_clk) disable iff (!reset_n)
    acc_valid && clk_en && in_reg && !local_hit
    |=> tgt_gaddr_reg == {2'b00, $past(acc_addr)})
    else $error("register address not passed through");
  AST_UNMAPPED_FWD: assert property (@(posedge sys_clk) disable iff (!reset_n)
    acc_valid && clk_en && sel == TGT_UNMAPPED
    |=> tgt_valid_reg && tgt_sel_reg == TGT_UNMAPPED)
    else $error("unmapped access not forwarded");

endmodule // device_address_decoder
`default_nettype wire

// file: rtl/addr_decode_pkg.sv
// Package holding the address map, windows and identifier layout of the address decoder
`default_nettype none
package addr_decode_pkg;
  // Register space windows (inclusive bounds, local byte addresses)
  localparam logic [15:0] REG_SPACE_END  = 16'h03ff;
  localparam logic [15:0] PIM_A_LO       = 16'h0000;
  localparam logic [15:0] PIM_A_HI       = 16'h0009;
  localparam logic [15:0] MMC_A_LO       = 16'h000a;
  localparam logic [15:0] MMC_A_HI       = 16'h000b;
  localparam logic [15:0] PIM_B_LO       = 16'h000c;
  localparam logic [15:0] PIM_B_HI       = 16'h000d;
  localparam logic [15:0] MMC_B_LO       = 16'h0010;
  localparam logic [15:0] MMC_B_HI       = 16'h0017;
  localparam logic [15:0] PART_IDENT_HIGH_OFS = 16'h001a;
  localparam logic [15:0] PART_IDENT_LOW_OFS  = 16'h001b;
  localparam logic [15:0] PIM_C_LO       = 16'h001c;
  localparam logic [15:0] PIM_C_HI       = 16'h001f;
  localparam logic [15:0] DBG_LO         = 16'h0020;
  localparam logic [15:0] DBG_HI         = 16'h002f;
  localparam logic [15:0] CLK_A_LO       = 16'h0034;
  localparam logic [15:0] CLK_A_HI       = 16'h003f;
  localparam logic [15:0] TMR_LO         = 16'h0040;
  localparam logic [15:0] TMR_HI         = 16'h006f;
  localparam logic [15:0] ADC_LO         = 16'h0070;
  localparam logic [15:0] ADC_HI         = 16'h009f;
  localparam logic [15:0] PWM_LO         = 16'h00a0;
  localparam logic [15:0] PWM_HI         = 16'h00c7;
  localparam logic [15:0] ASY_LO         = 16'h00c8;
  localparam logic [15:0] ASY_HI         = 16'h00cf;
  localparam logic [15:0] SPI_LO         = 16'h00d8;
  localparam logic [15:0] SPI_HI         = 16'h00df;
  localparam logic [15:0] NVM_LO         = 16'h0100;
  localparam logic [15:0] NVM_HI         = 16'h0113;
  localparam logic [15:0] INT_ADDR       = 16'h0120;
  localparam logic [15:0] CAN_LO         = 16'h0140;
  localparam logic [15:0] CAN_HI         = 16'h017f;
  localparam logic [15:0] PIM_D_LO       = 16'h0240;
  localparam logic [15:0] PIM_D_HI       = 16'h027f;
  localparam logic [15:0] CLK_B_LO       = 16'h02f0;
  localparam logic [15:0] CLK_B_HI       = 16'h02ff;
  // Memory windows
  localparam logic [15:0] DFL_LO         = 16'h0400;
  localparam logic [15:0] DFL_HI         = 16'h13ff;
  localparam logic [17:0] DFL_GLOBAL_OFS = 18'h04000;
  localparam logic [15:0] RAM_LO         = 16'h1400;
  localparam logic [15:0] RAM_HI_STD     = 16'h27ff;
  localparam logic [15:0] RAM_HI_4K      = 16'h2fff;
  localparam logic [17:0] RAM_GLOBAL_OFS = 18'h30000;
  localparam logic [15:0] PFL_LOW_LO     = 16'h4000;
  localparam logic [15:0] PFL_LOW_HI     = 16'h7fff;
  localparam logic [15:0] PFL_PAGED_LO   = 16'h8000;
  localparam logic [15:0] PFL_PAGED_HI   = 16'hbfff;
  localparam logic [15:0] PFL_HIGH_LO    = 16'hc000;
  localparam logic [17:0] PFL_GLOBAL_OFS = 18'h30000;
  localparam int          PAGE_SHIFT     = 14;
  localparam int          PAGE_W         = 4;
  // Part identifier layout
  localparam int ID_MAJFAM_LSB = 12;
  localparam int ID_MINFAM_LSB = 6;
  localparam int ID_MAJREV_LSB = 4;
  localparam int ID_MINREV_LSB = 0;
  localparam logic [7:0] READ_ZERO = 8'h00;
  // Selected target of one access
  typedef enum logic [4:0] {
    TGT_NONE, TGT_RESERVED, TGT_IDENT, TGT_PORT, TGT_MMC, TGT_CLOCK, TGT_ADC, TGT_PWM,
    TGT_SPI, TGT_TIMER, TGT_DEBUG, TGT_ASYNC, TGT_NVM_REGS, TGT_INTC, TGT_CAN,
    TGT_DFLASH, TGT_RAM, TGT_PFLASH, TGT_UNMAPPED
  } target_t;
endpackage
`default_nettype wire

// file: verification/periph_sink_model.sv
// Far-side peripheral model that counts the writes the decoder forwards
`default_nettype none
module periph_sink_model (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic        tgt_valid_reg,
  input  wire logic        tgt_write_reg,
  output var  logic [15:0] write_count
);
  timeunit 1ns;
  timeprecision 1ns;
  // Any forwarded write is a state change on this side, so a dropped write shows here
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      write_count <= 16'h0000;
    end else if (tgt_valid_reg && tgt_write_reg) begin
      write_count <= write_count + 16'h0001;
    end
  end
endmodule // periph_sink_model
`default_nettype wire

// file: verification/device_address_decoder_test.sv
// Self-checking bench for the address decoder
`default_nettype none
module device_address_decoder_test;
  import addr_decode_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] ID  = {4'h5, 6'h2b, 2'h2, 4'h9}; // Arbitrary identifier fields
  localparam logic [15:0] VER = 16'h1234;                  // Arbitrary version word
  logic        sys_clk   = 1'b0;
  logic        reset_n   = 1'b0;
  logic        clk_en    = 1'b0;
  logic        acc_valid = 1'b0;
  logic        acc_write = 1'b0;
  logic [15:0] acc_addr  = 16'h0000;
  logic [7:0]  acc_wdata = 8'h00;
  logic [3:0]  flash_page_select = 4'h0;
  logic        tgt_valid_reg, tgt_write_reg, local_rvalid_reg;
  target_t     tgt_sel_reg;
  logic [17:0] tgt_gaddr_reg;
  logic [7:0]  tgt_wdata_reg, local_rdata_reg;
  logic [15:0] nvm_version_word_reg, write_count;
  target_t     r4_sel;
  logic [17:0] r4_gaddr;
  int          fail_count = 0;
  int          n_checks = 0;
  int          cyc = 0;
  // Window edges of the register space, reserved ranges last
  logic [15:0] ra [31] = '{16'h0000, 16'h0009, 16'h001c, 16'h001f, 16'h0240, 16'h027f,
    16'h000a, 16'h0010, 16'h0017, 16'h0034, 16'h003f, 16'h02f0, 16'h02ff, 16'h0070,
    16'h009f, 16'h00a0, 16'h00c7, 16'h00d8, 16'h00df, 16'h0040, 16'h006f, 16'h0020,
    16'h002f, 16'h00c8, 16'h00cf, 16'h000e, 16'h000f, 16'h00e0, 16'h00ff, 16'h0300, 16'h03ff};
  target_t     rt [31] = '{TGT_PORT, TGT_PORT, TGT_PORT, TGT_PORT, TGT_PORT, TGT_PORT,
    TGT_MMC, TGT_MMC, TGT_MMC, TGT_CLOCK, TGT_CLOCK, TGT_CLOCK, TGT_CLOCK, TGT_ADC, TGT_ADC,
    TGT_PWM, TGT_PWM, TGT_SPI, TGT_SPI, TGT_TIMER, TGT_TIMER, TGT_DEBUG, TGT_DEBUG,
    TGT_ASYNC, TGT_ASYNC, TGT_RESERVED, TGT_RESERVED, TGT_RESERVED, TGT_RESERVED,
    TGT_RESERVED, TGT_RESERVED};
  // Memory window edges and their global images
  logic [15:0] ma [8] = '{16'h0400, 16'h13ff, 16'h1400, 16'h27ff,
    16'h4000, 16'h7fff, 16'hc000, 16'hffff};
  logic [17:0] mg [8] = '{18'h04400, 18'h053ff, 18'h31400, 18'h327ff,
    18'h34000, 18'h37fff, 18'h3c000, 18'h3ffff};
  target_t     mt [8] = '{TGT_DFLASH, TGT_DFLASH, TGT_RAM, TGT_RAM,
    TGT_PFLASH, TGT_PFLASH, TGT_PFLASH, TGT_PFLASH};

  device_address_decoder #(.MAJOR_FAMILY(4'h5), .MINOR_FAMILY(6'h2b), .MAJOR_REV(2'h2),
    .MINOR_REV(4'h9), .RAM_4K(1'b0), .NVM_VERSION(VER)) device_address_decoder_inst (
    .sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en), .acc_valid(acc_valid),
    .acc_write(acc_write), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
    .flash_page_select(flash_page_select), .tgt_valid_reg(tgt_valid_reg),
    .tgt_write_reg(tgt_write_reg), .tgt_sel_reg(tgt_sel_reg), .tgt_gaddr_reg(tgt_gaddr_reg),
    .tgt_wdata_reg(tgt_wdata_reg), .local_rvalid_reg(local_rvalid_reg),
    .local_rdata_reg(local_rdata_reg), .nvm_version_word_reg(nvm_version_word_reg));
  // Second decoder on the 4 KB RAM variant so the longer RAM window is exercised
  device_address_decoder #(.MAJOR_FAMILY(4'h5), .MINOR_FAMILY(6'h2b), .MAJOR_REV(2'h2),
    .MINOR_REV(4'h9), .RAM_4K(1'b1), .NVM_VERSION(VER)) device_address_decoder_ram4k_inst (
    .sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en), .acc_valid(acc_valid),
    .acc_write(acc_write), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
    .flash_page_select(flash_page_select), .tgt_valid_reg(), .tgt_write_reg(),
    .tgt_sel_reg(r4_sel), .tgt_gaddr_reg(r4_gaddr), .tgt_wdata_reg(),
    .local_rvalid_reg(), .local_rdata_reg(), .nvm_version_word_reg());
  periph_sink_model periph_sink_model_inst (.sys_clk(sys_clk), .reset_n(reset_n),
    .tgt_valid_reg(tgt_valid_reg), .tgt_write_reg(tgt_write_reg), .write_count(write_count));

  // Clock and a hang guard sized well above the roughly one hundred cycles the tests need
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc > 3000) begin
      fail_count++;
      end_sim();
    end
  end

  task automatic chk(input string nm, input logic [17:0] exp, input logic [17:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One access: inputs settle 1 ns after an edge, answer read 1 ns after the taking edge.
  // Valid stays up between back-to-back calls so no signal is assigned twice at once.
  task automatic acc(input logic wr, input logic [15:0] a, input logic [7:0] d);
    acc_valid = 1'b1;
    acc_write = wr;
    acc_addr = a;
    acc_wdata = d;
    @(posedge sys_clk);
    #1;
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    logic [15:0] wc;
    logic        rsv;
    repeat (10) @(posedge sys_clk);
    #1;
    reset_n = 1'b1;
    clk_en = 1'b1;
    for (int i = 0; i < 31; i++) begin
      wc = write_count;
      rsv = (rt[i] == TGT_RESERVED);
      acc(1'b1, ra[i], ra[i][7:0] ^ 8'h5a);
      chk("sel", {13'h0, rt[i]}, {13'h0, tgt_sel_reg});
      chk("fwd", {17'h0, !rsv}, {17'h0, tgt_valid_reg & tgt_write_reg});
      if (!rsv) begin
        chk("gaddr", {2'h0, ra[i]}, tgt_gaddr_reg);
        chk("wdata", {10'h0, ra[i][7:0] ^ 8'h5a}, {10'h0, tgt_wdata_reg});
      end
      acc(1'b0, ra[i], 8'h00);
      chk("count", {2'h0, wc + {15'h0, !rsv}}, {2'h0, write_count});
      chk("rvalid", {17'h0, rsv}, {17'h0, local_rvalid_reg});
      chk("rfwd", {17'h0, !rsv}, {17'h0, tgt_valid_reg});
      if (rsv) chk("rdata", 18'h0, {10'h0, local_rdata_reg});
    end
    chk("version", {2'h0, VER}, {2'h0, nvm_version_word_reg});
    for (int i = 0; i < 8; i++) begin
      acc(1'b1, ma[i], 8'hc3);
      chk("sel", {13'h0, mt[i]}, {13'h0, tgt_sel_reg});
      chk("gaddr", mg[i], tgt_gaddr_reg);
      chk("fwd", 18'h1, {17'h0, tgt_valid_reg & tgt_write_reg});
    end
    // RAM end on the 4 KB variant; the standard part leaves it unmapped but forwarded
    acc(1'b0, 16'h2fff, 8'h00);
    chk("r4sel", {13'h0, TGT_RAM}, {13'h0, r4_sel});
    chk("r4gaddr", 18'h32fff, r4_gaddr);
    chk("unmapped", {13'h0, TGT_UNMAPPED}, {13'h0, tgt_sel_reg});
    chk("unmfwd", 18'h1, {17'h0, tgt_valid_reg});
    // Every page value lands in the paged window
    for (int p = 0; p < 16; p++) begin
      flash_page_select = p[3:0];
      acc(1'b0, 16'h8000 | {2'b00, 14'(p * 14'h0411)}, 8'h00);
      chk("page", {p[3:0], 14'(p * 14'h0411)}, tgt_gaddr_reg);
      chk("psel", {13'h0, TGT_PFLASH}, {13'h0, tgt_sel_reg});
    end
    // Identifier: both bytes, a refused write, then an unchanged reread
    acc(1'b0, 16'h001a, 8'h00);
    chk("idh", {10'h0, ID[15:8]}, {10'h0, local_rdata_reg});
    chk("idsel", {13'h0, TGT_IDENT}, {13'h0, tgt_sel_reg});
    acc(1'b0, 16'h001b, 8'h00);
    chk("idl", {10'h0, ID[7:0]}, {10'h0, local_rdata_reg});
    chk("idrv", 18'h1, {17'h0, local_rvalid_reg});
    acc(1'b1, 16'h001a, 8'hff);
    chk("idwr", 18'h0, {17'h0, tgt_valid_reg});
    acc(1'b0, 16'h001a, 8'h00);
    chk("idh2", {10'h0, ID[15:8]}, {10'h0, local_rdata_reg});
    // Frozen clock enable: a request is not taken
    @(posedge sys_clk);
    #1;
    clk_en = 1'b0;
    acc(1'b1, 16'h0400, 8'h11);
    chk("frozen", 18'h0, {17'h0, tgt_valid_reg});
    clk_en = 1'b1;
    acc_valid = 1'b0;
    end_sim();
  end
endmodule // device_address_decoder_test
`default_nettype wire
